// ---- rtl/sfca_regs.vh ----
// Register offsets, field positions, codes and timing for the feedforward
// checker and network alarm block.
// Assumes inclusion by bare name from every file that needs the map.
`ifndef SFCA_REGS_VH
`define SFCA_REGS_VH
// Byte offsets of the AXI4-Lite registers.
`define SFCA_OFS_CTRL 8'h00
`define SFCA_OFS_ALM_CLR 8'h04
`define SFCA_OFS_VEL_LIM 8'h08
`define SFCA_OFS_TRQ_LIM 8'h0C
`define SFCA_OFS_STATUS 8'h10
`define SFCA_OFS_HIST 8'h14
`define SFCA_OFS_LAST 8'h18
`define SFCA_OFS_VFF 8'h1C
`define SFCA_OFS_TFF 8'h20
// Control register fields: two-bit selectors, frame size bit, mode.
`define SFCA_CTRL_D3_LSB 0
`define SFCA_CTRL_S2_LSB 2
`define SFCA_CTRL_S3_LSB 4
`define SFCA_CTRL_F32_BIT 6
`define SFCA_CTRL_MODE_LSB 8
`define SFCA_CTRL_RST 32'h0000_0000
`define SFCA_LIM_RST 32'h0000_FFFF
// Feedforward field selector codes.
`define SFCA_SEL_OFF 2'h0
`define SFCA_SEL_VEL 2'h1
`define SFCA_SEL_TRQ 2'h2
// Control modes.
`define SFCA_MODE_CP 2'h0
`define SFCA_MODE_PP 2'h1
`define SFCA_MODE_CV 2'h2
`define SFCA_MODE_CT 2'h3
// Command error codes.
`define SFCA_ERR_NONE 16'h0000
`define SFCA_ERR_RANGE 16'h0034
`define SFCA_ERR_OT 16'h0046
// Link answers and limits.
`define SFCA_NODE_MAX 8'h1F
`define SFCA_RESP_BAD 8'hFF
`define SFCA_AXI_OKAY 2'h0
`define SFCA_AXI_SLVERR 2'h2
// Alarm codes as {main, sub}, main in hex (82 decimal is 52h).
`define SFCA_ALM_82_0 12'h520
`define SFCA_ALM_83_0 12'h530
`define SFCA_ALM_83_1 12'h531
`define SFCA_ALM_84_0 12'h540
`define SFCA_ALM_84_3 12'h543
`define SFCA_ALM_84_5 12'h545
`define SFCA_ALM_86_0 12'h560
`define SFCA_ALM_86_1 12'h561
`define SFCA_ALM_86_2 12'h562
`define SFCA_ALM_90_2 12'h5A2
`define SFCA_ALM_91_1 12'h5B1
`define SFCA_ALM_98_1 12'h621
`define SFCA_ALM_98_2 12'h622
`define SFCA_ALM_98_3 12'h623
`define SFCA_ALM_N 14
// Alarm attribute bits: history, clearable, immediate stop, blinking.
`define SFCA_AT_HIST 3
`define SFCA_AT_CLR 2
`define SFCA_AT_STOP 1
`define SFCA_AT_BLINK 0
// Timing.
`define SFCA_CLK_KHZ 100000
`define SFCA_BLINK_MS 250
`define SFCA_CRC_FRAMES 3
`define SFCA_CHK_WAIT 2'h3
`endif

// ---- rtl/sfca_ff_chk.v ----
// One feedforward channel: checks a received value and holds the applied one.
// Assumes enable, support and stop qualifiers come from the same clock.
`include "sfca_regs.vh"
module sfca_ff_chk
(
	// Clock, reset and enable.
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// Frame qualifiers.
	input wire upd_i,
	input wire en_i,
	input wire sup_i,
	input wire prev_sup_i,
	input wire mode_sw_i,
	input wire force_zero_i,
	input wire ot_pos_i,
	input wire ot_neg_i,
	input wire [31:0] cmd_i,
	input wire [31:0] lim_i,
	// Results.
	output reg [31:0] ff_o,
	output reg [15:0] err_o
);

	reg [31:0] held_q;
	reg [31:0] held_d;
	reg [15:0] err_d;
	wire out_rng;
	wire neg;
	wire pos;

	// Range is symmetric about zero; the limit is taken as a magnitude.
	assign out_rng = ($signed(cmd_i) > $signed(lim_i)) ||
		($signed(cmd_i) < -$signed(lim_i));
	assign neg = cmd_i[31];
	assign pos = !cmd_i[31] && (cmd_i != 32'h0);

	// Decide the held value and the error code for a good frame.
	always @*
	begin
		held_d = held_q;
		err_d = `SFCA_ERR_NONE;
		if (upd_i)
		begin
			if (!en_i)
				held_d = 32'h0;
			else if (out_rng)
			begin
				err_d = `SFCA_ERR_RANGE;
				if (mode_sw_i && !prev_sup_i)
					held_d = 32'h0;
			end
			else if ((ot_pos_i && pos) || (ot_neg_i && neg))
			begin
				err_d = `SFCA_ERR_OT;
				held_d = 32'h0;
			end
			else
				held_d = cmd_i;
		end
		// An unsupported type never keeps a value, frame or not.
		if (!sup_i)
			held_d = 32'h0;
	end

	// Register the held value, the applied value and the error code.
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			held_q <= 32'h0;
			ff_o <= 32'h0;
			err_o <= `SFCA_ERR_NONE;
		end
		else if (ce_i)
		begin
			held_q <= held_d;
			// Stops zero only the applied value so the held one survives.
			ff_o <= (force_zero_i || !en_i) ? 32'h0 : held_d;
			if (upd_i)
				err_o <= err_d;
		end
	end

endmodule // sfca_ff_chk

// ---- rtl/sfca_top.v ----
// Feedforward checker and network alarm block with an AXI4-Lite slave.
// Assumes frame strobes and decoded fields arrive on ref_clk_i; switch and
// overtravel pins are asynchronous and are synchronised here.
// Operation
// - Velocity feedforward only in cyclic position; torque in all but torque mode.
// - Several feedforward selections in 32-byte frames raise a setting error.
// - A disabled data3 feedforward field must carry zero, else error 0034h.
// - Feedforward stays active during servo-lock after homing.
// - Applied feedforward is zero during a deceleration-and-stop sequence for servo off, counter clear or overtravel.
// - Value toward an inhibited direction after stop gives 0046h and zero.
// - Out-of-range value gives 0034h and keeps the last valid value.
// - Same on mode switch; zero if the old mode did not support it.
// - Unsupported feedforward type in the current mode is held at zero.
// - Node address alarm 82.0: history, not clearable, steady red.
// - Address switch outside 0 to 31 raises it, checked at start or reset.
// - On that alarm the link stays in startup and never runs.
// - Persistent CRC errors raise 83.0: clearable, stop, blinking red.
// - Alarm 84.3: history, not clearable, no stop, steady red.
// - Alarms 84.5 and 84.0: clearable, stop, blinking red.
// - Alarms 86.0 and 86.1: clearable, stop, blinking red.
// - Alarm 86.2: not clearable, immediate stop, steady red.
// - Alarm 90.2: history, not clearable, no stop, steady red.
// - Alarm 91.1: clearable, stop, blinking red.
// - Alarms 98.1 to 98.3: history, not clearable, no stop, steady red.
// - Bad frame is dropped, byte 1 answers FFh, link keeps active_link_state.
`include "sfca_regs.vh"
module sfca_top
#(
	parameter CRC_FRAMES = `SFCA_CRC_FRAMES,
	parameter BLINK_CYC = `SFCA_BLINK_MS * `SFCA_CLK_KHZ
)
(
	// Clock, reset and enable.
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// AXI4-Lite slave.
	input wire [7:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [7:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// Decoded cyclic frame.
	input wire frame_stb_i,
	input wire crc_err_i,
	input wire [31:0] cmd_data3_i,
	input wire [31:0] sub_data2_i,
	input wire [31:0] sub_data3_i,
	input wire [7:0] resp_stat_i,
	input wire reset_cmd_i,
	input wire alm_clr_cmd_i,
	// Drive state and pins.
	input wire servo_off_i,
	input wire cnt_clr_i,
	input wire stop_busy_i,
	input wire positive_overtravel_inhibit_i,
	input wire negative_overtravel_inhibit_i,
	input wire [7:0] node_addr_pin_i,
	input wire [11:0] alm_evt_i,
	// Results.
	output wire [31:0] velocity_feedforward_o,
	output wire [31:0] torque_feedforward_o,
	output reg [15:0] cmd_err_o,
	output reg cmd_err_stb_o,
	output reg [7:0] resp_byte1_o,
	output reg resp_stb_o,
	output reg active_link_state_o,
	output reg alarm_o,
	output reg imm_stop_o,
	output reg led_red_o,
	output reg cfg_err_o
);

	localparam [2:0] ST_CHK = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_HALT = 3'h4;
	localparam N = `SFCA_ALM_N;

	// Alarm code table.
	function [11:0] alm_code;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: alm_code = `SFCA_ALM_82_0;
				4'h1: alm_code = `SFCA_ALM_83_0;
				4'h2: alm_code = `SFCA_ALM_83_1;
				4'h3: alm_code = `SFCA_ALM_84_0;
				4'h4: alm_code = `SFCA_ALM_84_3;
				4'h5: alm_code = `SFCA_ALM_84_5;
				4'h6: alm_code = `SFCA_ALM_86_0;
				4'h7: alm_code = `SFCA_ALM_86_1;
				4'h8: alm_code = `SFCA_ALM_86_2;
				4'h9: alm_code = `SFCA_ALM_90_2;
				4'hA: alm_code = `SFCA_ALM_91_1;
				4'hB: alm_code = `SFCA_ALM_98_1;
				4'hC: alm_code = `SFCA_ALM_98_2;
				4'hD: alm_code = `SFCA_ALM_98_3;
				default: alm_code = 12'h000;
			endcase
		end
	endfunction

	// Attributes {history, clearable, stop, blink}; every alarm is recorded.
	function [3:0] alm_attr;
		input [3:0] idx;
		begin
			case (idx)
				4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA:
					alm_attr = 4'hF;
				4'h8: alm_attr = 4'hA;
				default: alm_attr = 4'h8;
			endcase
		end
	endfunction

	// Which field feeds a feedforward kind: 0 none, 1 data3, 2 sub2, 3 sub3.
	function [1:0] pick_src;
		input [31:0] ctrl;
		input [1:0] kind;
		begin
			if (ctrl[`SFCA_CTRL_D3_LSB+1:`SFCA_CTRL_D3_LSB] == kind)
				pick_src = 2'h1;
			else if (ctrl[`SFCA_CTRL_F32_BIT] &&
				ctrl[`SFCA_CTRL_S2_LSB+1:`SFCA_CTRL_S2_LSB] == kind)
				pick_src = 2'h2;
			else if (ctrl[`SFCA_CTRL_F32_BIT] &&
				ctrl[`SFCA_CTRL_S3_LSB+1:`SFCA_CTRL_S3_LSB] == kind)
				pick_src = 2'h3;
			else
				pick_src = 2'h0;
		end
	endfunction

	// Mode support for each kind of feedforward.
	function mode_sup;
		input [1:0] mode;
		input [1:0] kind;
		begin
			if (kind == `SFCA_SEL_VEL)
				mode_sup = (mode == `SFCA_MODE_CP);
			else
				mode_sup = (mode != `SFCA_MODE_CT);
		end
	endfunction

	// Byte-lane merge of a write into a stored word.
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1)
				wmerge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	reg [2:0] st_q;
	reg [1:0] chk_cnt_q;
	reg [7:0] node_m_q, node_s_q;
	reg [1:0] ot_m_q, ot_s_q;
	reg aw_hold_q, w_hold_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [31:0] ctrl_q, vlim_q, tlim_q;
	reg sw_clr_q;
	reg [1:0] frame_mode_q;
	reg done_q, dis_err_q;
	reg [7:0] crc_cnt_q;
	reg [N-1:0] pend_q, hist_q, pend_d, hist_d, set_v, clr_v;
	reg [11:0] last_q, last_d;
	reg [31:0] blink_cnt_q;
	reg phase_q;
	reg [31:0] rd_v;
	reg rd_ok;
	reg steady_v, blink_v, stop_v;
	reg [3:0] at_v;
	integer i;
	wire wr_go;
	wire run;
	wire upd;
	wire bad_frame;
	wire clr_cmd;
	wire node_alm;
	wire crc_alm;
	wire force_zero;
	wire [1:0] mode;
	wire [1:0] vsrc, tsrc;
	wire [31:0] vcmd, tcmd;
	wire [15:0] verr, terr;
	wire [1:0] nsel;

	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
	assign run = (st_q == ST_RUN);
	assign bad_frame = frame_stb_i && run && crc_err_i;
	assign upd = frame_stb_i && run && !crc_err_i;
	assign clr_cmd = sw_clr_q || (alm_clr_cmd_i && run);
	assign mode = ctrl_q[`SFCA_CTRL_MODE_LSB+1:`SFCA_CTRL_MODE_LSB];
	assign vsrc = pick_src(ctrl_q, `SFCA_SEL_VEL);
	assign tsrc = pick_src(ctrl_q, `SFCA_SEL_TRQ);
	assign vcmd = (vsrc == 2'h1) ? cmd_data3_i :
		(vsrc == 2'h2) ? sub_data2_i : sub_data3_i;
	assign tcmd = (tsrc == 2'h1) ? cmd_data3_i :
		(tsrc == 2'h2) ? sub_data2_i : sub_data3_i;
	// Count of active sub selectors; data3 adds one more if used.
	assign nsel = {1'h0, ctrl_q[`SFCA_CTRL_S2_LSB+1:`SFCA_CTRL_S2_LSB] != 2'h0}
		+ {1'h0, ctrl_q[`SFCA_CTRL_S3_LSB+1:`SFCA_CTRL_S3_LSB] != 2'h0}
		+ {1'h0, ctrl_q[`SFCA_CTRL_D3_LSB+1:`SFCA_CTRL_D3_LSB] != 2'h0};
	// Homing servo-lock is not a stop, so it does not zero feedforward.
	assign force_zero = stop_busy_i && (servo_off_i || cnt_clr_i ||
		ot_s_q[1] || ot_s_q[0]);
	assign node_alm = (st_q == ST_CHK) && (chk_cnt_q == `SFCA_CHK_WAIT) &&
		(node_s_q > `SFCA_NODE_MAX);
	assign crc_alm = bad_frame &&
		(crc_cnt_q == CRC_FRAMES[7:0] - 8'h01);

	// Pin synchronisers; only the second stage is looked at.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			node_m_q <= 8'h00;
			node_s_q <= 8'h00;
			ot_m_q <= 2'h0;
			ot_s_q <= 2'h0;
		end
		else if (ce_i)
		begin
			node_m_q <= node_addr_pin_i;
			node_s_q <= node_m_q;
			ot_m_q <= {positive_overtravel_inhibit_i,
				negative_overtravel_inhibit_i};
			ot_s_q <= ot_m_q;
		end
	end

	// Link state: check the address, then run, or stay halted in startup.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= ST_CHK;
			chk_cnt_q <= 2'h0;
		end
		else if (ce_i)
		begin
			case (st_q)
				ST_CHK:
				begin
					// Waiting lets the synchroniser settle before the check.
					if (chk_cnt_q != `SFCA_CHK_WAIT)
						chk_cnt_q <= chk_cnt_q + 2'h1;
					else if (node_alm || pend_q[0])
						st_q <= ST_HALT;
					else
						st_q <= ST_RUN;
				end
				ST_RUN:
				begin
					// A bad frame keeps the link active_link_state.
					if (reset_cmd_i)
					begin
						st_q <= ST_CHK;
						chk_cnt_q <= 2'h0;
					end
				end
				ST_HALT:
				begin
					if (reset_cmd_i)
					begin
						st_q <= ST_CHK;
						chk_cnt_q <= 2'h0;
					end
				end
				default: st_q <= ST_CHK;
			endcase
		end
	end

	// AXI4-Lite handshakes; address and data may arrive in either order.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_awready_o <= 1'h0;
			s_axi_wready_o <= 1'h0;
			s_axi_bvalid_o <= 1'h0;
			s_axi_bresp_o <= `SFCA_AXI_OKAY;
			s_axi_arready_o <= 1'h0;
			s_axi_rvalid_o <= 1'h0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `SFCA_AXI_OKAY;
			aw_hold_q <= 1'h0;
			w_hold_q <= 1'h0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else if (ce_i)
		begin
			if (!aw_hold_q && !s_axi_bvalid_o && !s_axi_awready_o)
				s_axi_awready_o <= 1'h1;
			if (!w_hold_q && !s_axi_bvalid_o && !s_axi_wready_o)
				s_axi_wready_o <= 1'h1;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_hold_q <= 1'h1;
				aw_addr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'h0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_hold_q <= 1'h1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'h0;
			end
			if (wr_go)
			begin
				aw_hold_q <= 1'h0;
				w_hold_q <= 1'h0;
				s_axi_bvalid_o <= 1'h1;
				s_axi_bresp_o <= (aw_addr_q == `SFCA_OFS_CTRL ||
					aw_addr_q == `SFCA_OFS_ALM_CLR ||
					aw_addr_q == `SFCA_OFS_VEL_LIM ||
					aw_addr_q == `SFCA_OFS_TRQ_LIM) ?
					`SFCA_AXI_OKAY : `SFCA_AXI_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'h0;
			if (!s_axi_rvalid_o && !s_axi_arready_o)
				s_axi_arready_o <= 1'h1;
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_arready_o <= 1'h0;
				s_axi_rvalid_o <= 1'h1;
				s_axi_rdata_o <= rd_v;
				s_axi_rresp_o <= rd_ok ? `SFCA_AXI_OKAY : `SFCA_AXI_SLVERR;
			end
			if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'h0;
		end
	end

	// Read decode; unmapped addresses read zero with an error response.
	always @*
	begin
		rd_v = 32'h0;
		rd_ok = 1'h1;
		case (s_axi_araddr_i)
			`SFCA_OFS_CTRL: rd_v = ctrl_q;
			`SFCA_OFS_ALM_CLR: rd_v = 32'h0;
			`SFCA_OFS_VEL_LIM: rd_v = vlim_q;
			`SFCA_OFS_TRQ_LIM: rd_v = tlim_q;
			`SFCA_OFS_STATUS: rd_v = {15'h0, cfg_err_o, run, 1'h0, pend_q};
			`SFCA_OFS_HIST: rd_v = {18'h0, hist_q};
			`SFCA_OFS_LAST: rd_v = {cmd_err_o, 4'h0, last_q};
			`SFCA_OFS_VFF: rd_v = velocity_feedforward_o;
			`SFCA_OFS_TFF: rd_v = torque_feedforward_o;
			default: rd_ok = 1'h0;
		endcase
	end

	// Software registers; the clear register only makes a one-cycle pulse.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q <= `SFCA_CTRL_RST;
			vlim_q <= `SFCA_LIM_RST;
			tlim_q <= `SFCA_LIM_RST;
			sw_clr_q <= 1'h0;
		end
		else if (ce_i)
		begin
			sw_clr_q <= wr_go && aw_addr_q == `SFCA_OFS_ALM_CLR &&
				w_strb_q[0] && w_data_q[0];
			if (wr_go && aw_addr_q == `SFCA_OFS_CTRL)
				ctrl_q <= wmerge(ctrl_q, w_data_q, w_strb_q);
			if (wr_go && aw_addr_q == `SFCA_OFS_VEL_LIM)
				vlim_q <= wmerge(vlim_q, w_data_q, w_strb_q);
			if (wr_go && aw_addr_q == `SFCA_OFS_TRQ_LIM)
				tlim_q <= wmerge(tlim_q, w_data_q, w_strb_q);
		end
	end

	// The two feedforward channels share one checker design.
	sfca_ff_chk u_vel
	(
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.upd_i(upd),
		.en_i(vsrc != 2'h0),
		.sup_i(mode_sup(mode, `SFCA_SEL_VEL)),
		.prev_sup_i(mode_sup(frame_mode_q, `SFCA_SEL_VEL)),
		.mode_sw_i(mode != frame_mode_q),
		.force_zero_i(force_zero),
		.ot_pos_i(ot_s_q[1] && !stop_busy_i),
		.ot_neg_i(ot_s_q[0] && !stop_busy_i),
		.cmd_i(vcmd),
		.lim_i(vlim_q),
		.ff_o(velocity_feedforward_o),
		.err_o(verr)
	);

	sfca_ff_chk u_trq
	(
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.upd_i(upd),
		.en_i(tsrc != 2'h0),
		.sup_i(mode_sup(mode, `SFCA_SEL_TRQ)),
		.prev_sup_i(mode_sup(frame_mode_q, `SFCA_SEL_TRQ)),
		.mode_sw_i(mode != frame_mode_q),
		.force_zero_i(force_zero),
		.ot_pos_i(ot_s_q[1] && !stop_busy_i),
		.ot_neg_i(ot_s_q[0] && !stop_busy_i),
		.cmd_i(tcmd),
		.lim_i(tlim_q),
		.ff_o(torque_feedforward_o),
		.err_o(terr)
	);

	// Frame answers, command errors and the persistent CRC counter.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			frame_mode_q <= `SFCA_MODE_CP;
			done_q <= 1'h0;
			dis_err_q <= 1'h0;
			crc_cnt_q <= 8'h00;
			cmd_err_o <= `SFCA_ERR_NONE;
			cmd_err_stb_o <= 1'h0;
			resp_byte1_o <= 8'h00;
			resp_stb_o <= 1'h0;
			cfg_err_o <= 1'h0;
		end
		else if (ce_i)
		begin
			done_q <= upd;
			resp_stb_o <= frame_stb_i && run;
			cfg_err_o <= ctrl_q[`SFCA_CTRL_F32_BIT] && (nsel > 2'h1);
			if (upd)
			begin
				frame_mode_q <= mode;
				dis_err_q <= (ctrl_q[`SFCA_CTRL_D3_LSB+1:`SFCA_CTRL_D3_LSB] ==
					`SFCA_SEL_OFF) && (cmd_data3_i != 32'h0);
				crc_cnt_q <= 8'h00;
				resp_byte1_o <= resp_stat_i;
			end
			if (bad_frame)
			begin
				resp_byte1_o <= `SFCA_RESP_BAD;
				if (crc_cnt_q != CRC_FRAMES[7:0])
					crc_cnt_q <= crc_cnt_q + 8'h01;
			end
			cmd_err_stb_o <= done_q;
			if (done_q)
				cmd_err_o <= dis_err_q ? `SFCA_ERR_RANGE :
					(verr != `SFCA_ERR_NONE) ? verr : terr;
		end
	end

	// Alarm set and clear; a new event beats a clear in the same cycle.
	always @*
	begin
		set_v = {alm_evt_i, crc_alm, node_alm};
		clr_v = {N{1'h0}};
		last_d = last_q;
		steady_v = 1'h0;
		blink_v = 1'h0;
		stop_v = 1'h0;
		at_v = 4'h0;
		for (i = N - 1; i >= 0; i = i - 1)
		begin
			at_v = alm_attr(i[3:0]);
			clr_v[i] = clr_cmd && at_v[`SFCA_AT_CLR];
			if (set_v[i])
				last_d = alm_code(i[3:0]);
			if (pend_q[i] && at_v[`SFCA_AT_BLINK])
				blink_v = 1'h1;
			if (pend_q[i] && !at_v[`SFCA_AT_BLINK])
				steady_v = 1'h1;
			if (pend_q[i] && at_v[`SFCA_AT_STOP])
				stop_v = 1'h1;
		end
		pend_d = set_v | (pend_q & ~clr_v);
		hist_d = set_v | (hist_q & ~clr_v);
	end

	// Alarm state, blink phase and indicator outputs.
	always @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			pend_q <= {N{1'h0}};
			hist_q <= {N{1'h0}};
			last_q <= 12'h000;
			blink_cnt_q <= 32'h0;
			phase_q <= 1'h0;
			alarm_o <= 1'h0;
			imm_stop_o <= 1'h0;
			led_red_o <= 1'h0;
			active_link_state_o <= 1'h0;
		end
		else if (ce_i)
		begin
			pend_q <= pend_d;
			hist_q <= hist_d;
			last_q <= last_d;
			if (blink_cnt_q == BLINK_CYC - 1)
			begin
				blink_cnt_q <= 32'h0;
				phase_q <= !phase_q;
			end
			else
				blink_cnt_q <= blink_cnt_q + 32'h1;
			alarm_o <= |pend_q;
			imm_stop_o <= stop_v;
			// A steady alarm outranks a blinking one on the shared lamp.
			led_red_o <= steady_v || (blink_v && phase_q);
			active_link_state_o <= run;
		end
	end

endmodule // sfca_top

// ---- verif/sfca_top_asserts.sv ----
// Checker for the feedforward and network alarm block, bound to its top.
// Assumes ce_i is held high by the bench whenever frames are sent.
module sfca_top_asserts (
	// Clock and controls.
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// Frame and pins.
	input wire frame_stb_i,
	input wire crc_err_i,
	input wire cnt_clr_i,
	input wire stop_busy_i,
	input wire [7:0] node_addr_pin_i,
	// Results.
	input wire [31:0] velocity_feedforward_o,
	input wire [31:0] torque_feedforward_o,
	input wire [15:0] cmd_err_o,
	input wire cmd_err_stb_o,
	input wire [7:0] resp_byte1_o,
	input wire resp_stb_o,
	input wire active_link_state_o,
	input wire alarm_o,
	input wire imm_stop_o,
	input wire led_red_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Frames the block must take, split by their CRC outcome.
	wire fr = frame_stb_i && ce_i && active_link_state_o;
	wire bad = fr && crc_err_i;
	wire good = fr && !crc_err_i;
	resp_echo_a:
	assert property (fr |=> resp_stb_o) else $error("no response strobe");
	crc_byte_a:
	assert property (bad |=> resp_byte1_o == 8'hFF) else $error("bad byte1");
	crc_keep_a:
	assert property (bad && !stop_busy_i |=> $stable(velocity_feedforward_o)
		&& $stable(torque_feedforward_o)) else $error("bad frame applied");
	err_time_a:
	assert property (good |-> ##2 cmd_err_stb_o) else $error("no error strobe");
	err_code_a:
	assert property (cmd_err_stb_o |-> cmd_err_o inside {16'h0000, 16'h0034,
		16'h0046}) else $error("illegal error code");
	stop_zero_a:
	assert property ((stop_busy_i && cnt_clr_i) [*3] |->
		velocity_feedforward_o == 32'h0 && torque_feedforward_o == 32'h0)
		else $error("feedforward not zero in stop");
	bad_addr_a:
	assert property ((!active_link_state_o && node_addr_pin_i > 8'h1F) [*8]
		|=> !active_link_state_o) else $error("link up with bad address");
	no_resp_a:
	assert property (frame_stb_i ##1 !active_link_state_o |-> !resp_stb_o)
		else $error("answer outside active_link_state state");
	stop_alm_a:
	assert property (imm_stop_o |-> alarm_o) else $error("stop without alarm");
	lamp_off_a:
	assert property (!alarm_o ##1 !alarm_o |-> !led_red_o)
		else $error("lamp lit without alarm");
	// Main scenarios seen at least once.
	cover property (bad);
	cover property (good ##2 cmd_err_o == 16'h0034);
	cover property (alarm_o && led_red_o);
endmodule // sfca_top_asserts

bind sfca_top sfca_top_asserts i_chk (.*);

// ---- verif/sfca_host.sv ----
// Host controller model: sends one cyclic frame per call of send.
// Assumes the caller enters send just after a rising clock edge.
module sfca_host (
	// Clock.
	input wire clk_i,
	// Frame lines.
	output logic stb_o,
	output logic crc_o,
	output logic [31:0] d_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The idle data line starts scrambled, never as a usable value; strobe and CRC flag start low.
	initial
	begin
		stb_o = 1'b0;
		crc_o = 1'b0;
		d_o = 32'hA5A5A5A5;
	end
	// Fields are inverted after the frame so stale data cannot pass as new;
	// the call returns once the error code of the frame has landed.
	task automatic send(input logic c, input logic [31:0] d);
	begin
		stb_o <= 1'b1;
		crc_o <= c;
		d_o <= d;
		@(posedge clk_i);
		stb_o <= 1'b0;
		crc_o <= ~c;
		d_o <= ~d;
		repeat (3) @(posedge clk_i);
	end
	endtask
endmodule // sfca_host

// ---- verif/sfca_top_tb_top.sv ----
// Bench for the feedforward checker and network alarm block.
// Assumes the host model and the bound checker are compiled alongside.
module sfca_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, rst_n_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, frame_stb_i;
	logic crc_err_i, reset_cmd_i, alm_clr_cmd_i, servo_off_i, cnt_clr_i;
	logic stop_busy_i, positive_overtravel_inhibit_i;
	logic negative_overtravel_inhibit_i;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, node_addr_pin_i, resp_byte1_o;
	logic [31:0] s_axi_wdata_i, cmd_data3_i, s_axi_rdata_o;
	logic [31:0] velocity_feedforward_o, torque_feedforward_o;
	logic [3:0] s_axi_wstrb_i;
	logic [11:0] alm_evt_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [15:0] cmd_err_o;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o, cmd_err_stb_o, resp_stb_o, active_link_state_o;
	logic alarm_o, imm_stop_o, led_red_o, cfg_err_o;
	// Sub fields follow the host data so they are never constant.
	wire [31:0] sub_data2_i = cmd_data3_i;
	wire [31:0] sub_data3_i = ~cmd_data3_i;
	wire [7:0] resp_stat_i = cmd_data3_i[7:0];
	int checks = 0, miscompares = 0;
	localparam logic [1:0] OK = 2'h0, SE = 2'h2;

	sfca_top #(.BLINK_CYC(4)) i_sfca_top (.*);
	sfca_host i_sfca_host (.clk_i(ref_clk_i), .stb_o(frame_stb_i),
		.crc_o(crc_err_i), .d_o(cmd_data3_i));

	// Free-active_link_state 100 MHz clock.
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic test_done();
	begin
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
	begin
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	end
	endtask

	// A wait that ran out of cycles ends the run as a failure.
	task automatic tmo(input int n);
	begin
		if (n >= 50)
		begin
			miscompares++;
			test_done();
		end
	end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
	begin
		n = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			n++;
			if (s_axi_awready_o && s_axi_awvalid_i)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o && s_axi_wvalid_i)
				s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o && n < 50);
		s_axi_bready_i <= 1'b0;
		chk("bresp", s_axi_bresp_o, r);
		tmo(n);
		@(posedge ref_clk_i);
	end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		int n;
	begin
		n = 0;
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			n++;
			if (s_axi_arready_o && s_axi_arvalid_i)
				s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o && n < 50);
		s_axi_rready_i <= 1'b0;
		chk("rdata", s_axi_rdata_o, e);
		chk("rresp", s_axi_rresp_o, r);
		tmo(n);
		@(posedge ref_clk_i);
	end
	endtask

	// The address switch changes only while reset is held.
	task automatic rst(input logic [7:0] a);
	begin
		node_addr_pin_i <= a;
		rst_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (12) @(posedge ref_clk_i);
	end
	endtask

	task automatic fv(input logic c, input logic [31:0] d, ev,
		input logic [15:0] ee);
	begin
		i_sfca_host.send(c, d);
		chk("vff", velocity_feedforward_o, ev);
		chk("err", cmd_err_o, ee);
	end
	endtask

	task automatic clr();
	begin
		alm_clr_cmd_i <= 1'b1;
		@(posedge ref_clk_i);
		alm_clr_cmd_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	end
	endtask

	// Main sequence.
	initial
	begin
		{ce_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i} = 4'h8;
		{s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 3'h0;
		{reset_cmd_i, alm_clr_cmd_i, servo_off_i, cnt_clr_i} = 4'h0;
		{stop_busy_i, positive_overtravel_inhibit_i,
			negative_overtravel_inhibit_i} = 3'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, node_addr_pin_i} = 24'h0;
		{s_axi_wdata_i, s_axi_wstrb_i, alm_evt_i} = 48'h0000000F000;
		rst(8'h1F);
		chk("run", active_link_state_o, 1'b1);
		rd(8'h00, 32'h0, OK);
		rd(8'h08, 32'h0000FFFF, OK);
		rd(8'h40, 32'h0, SE);
		wr(8'h10, 32'h1, SE);
		$display("end registers");
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h00, {22'h0, m[1:0], 8'h01}, OK);
			fv(1'b0, 32'h64, (m == 0) ? 32'h64 : 32'h0, 16'h0);
			wr(8'h00, {22'h0, m[1:0], 8'h02}, OK);
			i_sfca_host.send(1'b0, 32'h32);
			chk("tff", torque_feedforward_o, (m != 3) ? 32'h32 : 32'h0);
		end
		$display("end modes");
		wr(8'h08, 32'h10, OK);
		wr(8'h00, 32'h1, OK);
		fv(1'b0, 32'h10, 32'h10, 16'h0);
		fv(1'b0, 32'h11, 32'h10, 16'h0034);
		fv(1'b0, 32'hFFFFFFF0, 32'hFFFFFFF0, 16'h0);
		wr(8'h00, 32'h301, OK);
		fv(1'b0, 32'h5, 32'h0, 16'h0);
		wr(8'h00, 32'h1, OK);
		fv(1'b0, 32'h20, 32'h0, 16'h0034);
		wr(8'h00, 32'h0, OK);
		fv(1'b0, 32'h1, 32'h0, 16'h0034);
		fv(1'b0, 32'h0, 32'h0, 16'h0);
		wr(8'h49, 32'h0, SE);
		wr(8'h00, 32'h49, OK);
		repeat (2) @(posedge ref_clk_i);
		chk("cfg", cfg_err_o, 1'b1);
		wr(8'h00, 32'h09, OK);
		repeat (2) @(posedge ref_clk_i);
		chk("cfg", cfg_err_o, 1'b0);
		$display("end range");
		wr(8'h00, 32'h1, OK);
		negative_overtravel_inhibit_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		fv(1'b0, 32'hFFFFFFFB, 32'h0, 16'h0046);
		negative_overtravel_inhibit_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		fv(1'b0, 32'h7, 32'h7, 16'h0);
		cnt_clr_i <= 1'b1;
		stop_busy_i <= 1'b1;
		i_sfca_host.send(1'b0, 32'h5);
		chk("vff", velocity_feedforward_o, 32'h0);
		cnt_clr_i <= 1'b0;
		stop_busy_i <= 1'b0;
		fv(1'b0, 32'h7, 32'h7, 16'h0);
		repeat (3) fv(1'b1, 32'h9, 32'h7, 16'h0);
		chk("byte1", resp_byte1_o, 8'hFF);
		chk("stop", imm_stop_o, 1'b1);
		clr();
		chk("alarm", alarm_o, 1'b0);
		alm_evt_i <= 12'h040;
		@(posedge ref_clk_i);
		alm_evt_i <= 12'h000;
		repeat (8) @(posedge ref_clk_i);
		chk("stop", imm_stop_o, 1'b1);
		chk("led", led_red_o, 1'b1);
		clr();
		chk("alarm", alarm_o, 1'b1);
		$display("end alarms");
		rst(8'h20);
		chk("run", active_link_state_o, 1'b0);
		i_sfca_host.send(1'b0, 32'h1);
		chk("led", led_red_o, 1'b1);
		rd(8'h10, 32'h1, OK);
		rd(8'h14, 32'h1, OK);
		rst(8'h1F);
		chk("run", active_link_state_o, 1'b1);
		$display("end address");
		test_done();
	end
endmodule // sfca_top_tb_top
